//--- common/core_timer_pkg.sv
// shared constants and types for the core timer chain
// assumes a byte-wide cpu bus with 16-bit addresses, one clock domain
`default_nettype none

package core_timer_pkg;

	////////////////////////////////////////
	// bus map
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 8;
	localparam logic [15:0] CSR_ADDR = 16'h0008;
	localparam logic [15:0] COUNT_ADDR = 16'h0009;
	localparam logic [15:0] WDOG_SVC_ADDR = 16'hFFF0;
	localparam int unsigned WDOG_SVC_BIT = 0;

	////////////////////////////////////////
	// control/status field positions and reset value
	localparam int unsigned WRAP_FLAG_BIT = 7;
	localparam int unsigned PER_FLAG_BIT = 6;
	localparam int unsigned PER_CLEAR_BIT = 2;
	localparam logic [7:0] CSR_RESET = 8'h03;
	localparam int unsigned WRAP_EN_BIT = 5;
	localparam int unsigned PER_EN_BIT = 4;
	localparam int unsigned RATE_HI_BIT = 1;
	localparam int unsigned RATE_LO_BIT = 0;

	////////////////////////////////////////
	// divider chain shape
	localparam int unsigned PRESC_STAGES = 2;
	localparam int unsigned COUNT_STAGES = 8;
	localparam int unsigned MID_STAGES = 4;
	localparam int unsigned RTI_STAGES = 3;
	localparam int unsigned CHAIN_W = PRESC_STAGES + COUNT_STAGES + MID_STAGES + RTI_STAGES;
	localparam int unsigned WRAP_TAP = PRESC_STAGES + COUNT_STAGES - 1;
	localparam int unsigned RTI_BASE_TAP = WRAP_TAP + MID_STAGES;
	localparam int unsigned WDOG_STAGES = 3;
	localparam int unsigned POR_CYCLES = 4064;
	localparam int unsigned POR_W = 12;

	////////////////////////////////////////
	// types
	typedef struct packed {
		logic count_wrap_flag;
		logic periodic_flag;
		logic count_wrap_irq_enable;
		logic periodic_irq_enable;
		logic unused_b3;
		logic periodic_flag_clear;
		logic rate_select_hi;
		logic rate_select_lo;
	} csr_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

	typedef enum logic [2:0] {
		ST_POR = 3'b001,
		ST_HOLD = 3'b010,
		ST_RUN = 3'b100
	} chain_state_t;

endpackage

`default_nettype wire

//--- rtl/divider_chain.sv
// synchronous model of the ripple divider chain
// assumes one clock; every stage advances on the same edge as a carry
`default_nettype none

module divider_chain #(
	parameter int unsigned W = 17
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic clear_i,
	output logic [W-1:0] count_o,
	output logic [W-1:0] carry_o
);

	logic [W-1:0] count_q;
	logic [W-1:0] count_d;

	// carry k is high in the cycle where stages 0..k all roll over
	genvar k;
	generate
		for (k = 0; k < W; k++) begin : g_carry
			assign carry_o[k] = &count_q[k:0];
		end
	endgenerate

	// clear beats the increment so a restart always begins at zero
	assign count_d = clear_i ? '0 : count_q + {{(W-1){1'b0}}, 1'b1};

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			count_q <= '0;
		end else begin
			count_q <= count_d;
		end
	end

	assign count_o = count_q;

endmodule // divider_chain

`default_nettype wire

//--- rtl/watchdog_divider.sv
// final divide-by-eight watchdog stage
// assumes tick_i is a one-cycle pulse at the selected periodic rate
`default_nettype none

module watchdog_divider #(
	parameter int unsigned STAGES = 3
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic tick_i,
	input wire logic service_i,
	input wire logic clear_i,
	output logic timeout_o
);

	logic [STAGES-1:0] cnt_q;
	logic [STAGES-1:0] cnt_d;
	logic timeout_q;
	logic wrap_w;

	// only this stage is cleared by service; the chain runs on, so the
	// real timeout is between seven and eight periodic ticks
	assign wrap_w = tick_i && (&cnt_q) && !service_i && !clear_i;
	assign cnt_d = (service_i || clear_i) ? '0 :
		tick_i ? cnt_q + {{(STAGES-1){1'b0}}, 1'b1} : cnt_q;

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= '0;
			timeout_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			timeout_q <= wrap_w;
		end
	end

	assign timeout_o = timeout_q;

endmodule // watchdog_divider

`default_nettype wire

//--- rtl/core_timer_rti_watchdog.sv
// core timer: prescaler, readable 8-bit counter, periodic interrupt
// divider with rate taps, watchdog and power-on reset timing
// assumes bus signals are synchronous to clk_sys_i and the cpu
// samples read data one cycle after a read strobe
`default_nettype none

module core_timer_rti_watchdog #(
	parameter int unsigned POR_CYCLES = core_timer_pkg::POR_CYCLES,
	parameter bit WDOG_EN = 1'b1
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic ext_reset_n_i,
	input wire logic [core_timer_pkg::ADDR_W-1:0] bus_addr_i,
	input wire logic [core_timer_pkg::DATA_W-1:0] bus_wdata_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	output logic [core_timer_pkg::DATA_W-1:0] bus_rdata_o,
	output logic irq_o,
	output logic cpu_reset_o
);

	localparam int unsigned CW = core_timer_pkg::CHAIN_W;
	localparam int unsigned PW = core_timer_pkg::POR_W;
	localparam logic [PW-1:0] POR_LAST = PW'(POR_CYCLES - 1);

	////////////////////////////////////////
	// declarations
	core_timer_pkg::bus_req_t req_w;
	core_timer_pkg::csr_t csr_q;
	core_timer_pkg::csr_t csr_d;
	core_timer_pkg::csr_t csr_view_w;
	core_timer_pkg::chain_state_t state_q;
	core_timer_pkg::chain_state_t state_d;
	logic [CW-1:0] chain_count_w;
	logic [CW-1:0] chain_carry_w;
	logic [7:0] count_value_w;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic irq_q;
	logic irq_d;
	logic cpu_reset_q;
	logic cpu_reset_d;
	logic ext_reset_w;
	logic running_w;
	logic por_done_w;
	logic chain_clear_w;
	logic soft_reset_w;
	logic wrap_evt_w;
	logic rti_evt_w;
	logic wdog_timeout_w;
	logic wdog_service_w;
	logic wr_csr_w;
	logic rd_csr_w;
	logic rd_count_w;
	logic clear_wrap_w;
	logic clear_periodic_w;

	////////////////////////////////////////
	// helpers

	// chain carry index for a given rate select pair
	function automatic int unsigned tap_index(input logic hi, input logic lo);
		tap_index = core_timer_pkg::RTI_BASE_TAP + {30'd0, hi, lo};
	endfunction

	// bus decode is a plain compare; one function keeps all hits alike
	function automatic logic addr_hit(
		input logic [core_timer_pkg::ADDR_W-1:0] a,
		input logic [core_timer_pkg::ADDR_W-1:0] target
	);
		addr_hit = (a == target);
	endfunction

	////////////////////////////////////////
	// bus request bundle and address decode
	assign req_w.addr = bus_addr_i;
	assign req_w.wdata = bus_wdata_i;
	assign req_w.wr = bus_wr_i;
	assign req_w.rd = bus_rd_i;

	assign wr_csr_w = req_w.wr && addr_hit(req_w.addr, core_timer_pkg::CSR_ADDR);
	assign rd_csr_w = req_w.rd && addr_hit(req_w.addr, core_timer_pkg::CSR_ADDR);
	assign rd_count_w = req_w.rd && addr_hit(req_w.addr, core_timer_pkg::COUNT_ADDR);
	// a write to the counter address decodes to nothing at all, so the
	// count can only move by clocking or by a chain clear

	// service write: a zero in the service bit, any other bits ignored;
	// the address is compared in full so a near miss never services
	assign wdog_service_w = req_w.wr && WDOG_EN && running_w
		&& addr_hit(req_w.addr, core_timer_pkg::WDOG_SVC_ADDR)
		&& !req_w.wdata[core_timer_pkg::WDOG_SVC_BIT];

	////////////////////////////////////////
	// divider chain: prescaler, counter, mid stages, periodic stages
	divider_chain #(
		.W(CW)
	) u_chain (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.clear_i(chain_clear_w),
		.count_o(chain_count_w),
		.carry_o(chain_carry_w)
	);

	// readable counter sits above the two prescaler stages
	assign count_value_w =
		chain_count_w[core_timer_pkg::PRESC_STAGES +: core_timer_pkg::COUNT_STAGES];

	////////////////////////////////////////
	// chain events
	// both events are masked in the cycle the chain is cleared, so a
	// restart never shows a stale wrap or periodic tick
	assign running_w = (state_q == core_timer_pkg::ST_RUN);

	// counter rolls from all ones to zero when the carry reaches its top
	assign wrap_evt_w = running_w && !chain_clear_w
		&& chain_carry_w[core_timer_pkg::WRAP_TAP];

	// periodic taps sit at 2^14..2^17 bus clocks; the mid stages give
	// the 2^14 base and the periodic stages the three slower ones
	// limitation: moving the rate select while a tap rolls over can drop
	// or add one periodic tick; service the watchdog before changing it
	assign rti_evt_w = running_w && !chain_clear_w
		&& chain_carry_w[tap_index(csr_q.rate_select_hi, csr_q.rate_select_lo)];

	// power-on delay ends on the last cycle of the delay count
	// the delay shares the low chain bits, so a short POR_CYCLES only
	// shortens the wait and leaves the chain shape alone
	assign por_done_w = (state_q == core_timer_pkg::ST_POR)
		&& (chain_count_w[PW-1:0] == POR_LAST);

	////////////////////////////////////////
	// watchdog stage on the selected periodic tap
	// with the mask option off the stage never ticks, so never times out
	watchdog_divider #(
		.STAGES(core_timer_pkg::WDOG_STAGES)
	) u_wdog (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.tick_i(rti_evt_w && WDOG_EN),
		.service_i(wdog_service_w),
		.clear_i(!running_w),
		.timeout_o(wdog_timeout_w)
	);

	////////////////////////////////////////
	// reset sequencing
	assign ext_reset_w = !ext_reset_n_i;

	// power-on counts on the chain; hold keeps it cleared while any
	// reset source is active; run leaves on external or watchdog reset
	always_comb begin
		state_d = state_q;
		case (state_q)
			core_timer_pkg::ST_POR: begin
				if (por_done_w) begin
					state_d = ext_reset_w ? core_timer_pkg::ST_HOLD
						: core_timer_pkg::ST_RUN;
				end
			end
			core_timer_pkg::ST_HOLD: begin
				if (!ext_reset_w) begin
					state_d = core_timer_pkg::ST_RUN;
				end
			end
			core_timer_pkg::ST_RUN: begin
				if (ext_reset_w || wdog_timeout_w) begin
					state_d = core_timer_pkg::ST_HOLD;
				end
			end
			default: begin
				state_d = core_timer_pkg::ST_POR;
			end
		endcase
	end

	// chain cleared at the end of the delay, in hold, and on entry to hold
	assign chain_clear_w = por_done_w
		|| (state_q == core_timer_pkg::ST_HOLD)
		|| (running_w && (ext_reset_w || wdog_timeout_w));

	// registers return to reset values whenever the cpu is held in reset;
	// the entry edge counts too, so a read in the first held cycle sees
	// the reset value and not the last pre-reset contents
	assign soft_reset_w = !running_w
		|| (state_d != core_timer_pkg::ST_RUN);

	// cpu sees reset during the delay, in hold and for the timeout cycle
	assign cpu_reset_d = (state_d != core_timer_pkg::ST_RUN);

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_q <= core_timer_pkg::ST_POR;
		end else begin
			state_q <= state_d;
		end
	end

	////////////////////////////////////////
	// control/status register next value
	assign clear_wrap_w = wr_csr_w && !req_w.wdata[core_timer_pkg::WRAP_FLAG_BIT];
	assign clear_periodic_w = wr_csr_w && req_w.wdata[core_timer_pkg::PER_CLEAR_BIT];

	// a flag event in the same cycle as its clear keeps the flag set
	always_comb begin
		csr_d = csr_q;
		csr_d.count_wrap_flag = wrap_evt_w
			|| (csr_q.count_wrap_flag && !clear_wrap_w);
		csr_d.periodic_flag = rti_evt_w
			|| (csr_q.periodic_flag && !clear_periodic_w);
		if (wr_csr_w) begin
			csr_d.count_wrap_irq_enable = req_w.wdata[core_timer_pkg::WRAP_EN_BIT];
			csr_d.periodic_irq_enable = req_w.wdata[core_timer_pkg::PER_EN_BIT];
			csr_d.rate_select_hi = req_w.wdata[core_timer_pkg::RATE_HI_BIT];
			csr_d.rate_select_lo = req_w.wdata[core_timer_pkg::RATE_LO_BIT];
		end
		csr_d.unused_b3 = 1'b0;
		csr_d.periodic_flag_clear = 1'b0;
		if (soft_reset_w) begin
			csr_d = core_timer_pkg::CSR_RESET;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			csr_q <= core_timer_pkg::CSR_RESET;
		end else begin
			csr_q <= csr_d;
		end
	end

	////////////////////////////////////////
	// interrupt request, combined from both flag and enable pairs
	// gated by run, so irq_o can stay high only in the first cycle the cpu is held
	assign irq_d = running_w
		&& ((csr_q.count_wrap_flag && csr_q.count_wrap_irq_enable)
		|| (csr_q.periodic_flag && csr_q.periodic_irq_enable));

	////////////////////////////////////////
	// read path: the counter is sampled, never cleared, by a read
	assign csr_view_w = '{
		count_wrap_flag: csr_q.count_wrap_flag,
		periodic_flag: csr_q.periodic_flag,
		count_wrap_irq_enable: csr_q.count_wrap_irq_enable,
		periodic_irq_enable: csr_q.periodic_irq_enable,
		unused_b3: 1'b0,
		periodic_flag_clear: 1'b0,
		rate_select_hi: csr_q.rate_select_hi,
		rate_select_lo: csr_q.rate_select_lo
	};

	// unmapped addresses read as zero, so a stray read shows no state
	assign rdata_d = rd_csr_w ? csr_view_w
		: rd_count_w ? count_value_w
		: 8'h00;

	// read data holds until the next read strobe
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_q <= 8'h00;
		end else if (req_w.rd) begin
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////
	// registered outputs
	// cpu reset starts high so the cpu is held from the first edge
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_q <= 1'b0;
			cpu_reset_q <= 1'b1;
		end else begin
			irq_q <= irq_d;
			cpu_reset_q <= cpu_reset_d;
		end
	end

	assign bus_rdata_o = rdata_q;
	assign irq_o = irq_q;
	assign cpu_reset_o = cpu_reset_q;

endmodule // core_timer_rti_watchdog

`default_nettype wire

//--- bench/core_timer_chk.sv
// port checker for the core timer block
// assumes a bind into the timer top, one clock domain
`default_nettype none

module core_timer_chk #(
	parameter int unsigned POR_CYCLES = core_timer_pkg::POR_CYCLES,
	parameter bit WDOG_EN = 1'b1
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic ext_reset_n_i,
	input wire logic [15:0] bus_addr_i,
	input wire logic [7:0] bus_wdata_i,
	input wire logic bus_wr_i,
	input wire logic bus_rd_i,
	input wire logic [7:0] bus_rdata_o,
	input wire logic irq_o,
	input wire logic cpu_reset_o
);

	// decoded strobes, kept as nets so properties stay short
	wire logic rd_csr = bus_rd_i && bus_addr_i == core_timer_pkg::CSR_ADDR;
	wire logic rd_cnt = bus_rd_i && bus_addr_i == core_timer_pkg::COUNT_ADDR;
	wire logic wr_csr = bus_wr_i && bus_addr_i == core_timer_pkg::CSR_ADDR;

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);

	////////////////////////////////////////
	// reset paths
	ext_hold_a: assert property (!ext_reset_n_i |=> cpu_reset_o)
		else $error("no cpu reset after external reset");
	ext_csr_a: assert property (rd_csr && !ext_reset_n_i && cpu_reset_o
		|=> bus_rdata_o == core_timer_pkg::CSR_RESET) else $error("control not at reset value");
	reset_quiet_a: assert property (cpu_reset_o [*3] |-> !irq_o)
		else $error("interrupt during internal reset");

	////////////////////////////////////////
	// register reads; the count must step by one every four clocks
	rdata_hold_a: assert property (!bus_rd_i |=> $stable(bus_rdata_o))
		else $error("read data moved without a read");
	csr_gap_a: assert property (rd_csr |=> bus_rdata_o[3:2] == 2'b00)
		else $error("control bits 3 and 2 not zero");
	count_step_a: assert property ((rd_cnt && !cpu_reset_o) ##1 (!cpu_reset_o [*3])
		##1 (rd_cnt && !cpu_reset_o && ext_reset_n_i)
		|=> bus_rdata_o == $past(bus_rdata_o, 4) + 8'h01)
		else $error("count did not step by one");
	enable_keep_a: assert property ((wr_csr && !cpu_reset_o && ext_reset_n_i)
		##1 !cpu_reset_o ##1 (rd_csr && !cpu_reset_o && ext_reset_n_i)
		|=> bus_rdata_o[5:4] == $past(bus_wdata_i[5:4], 3))
		else $error("enable bits not kept");
	irq_cause_a: assert property (rd_csr ##1 ((bus_rdata_o[7] && bus_rdata_o[5])
		|| (bus_rdata_o[6] && bus_rdata_o[4])) |-> ##[0:1] irq_o) else $error("interrupt missing");

endmodule // core_timer_chk

bind core_timer_rti_watchdog core_timer_chk #(.POR_CYCLES(POR_CYCLES), .WDOG_EN(WDOG_EN)) chk_u (
	.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ext_reset_n_i(ext_reset_n_i),
	.bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i),
	.bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o), .irq_o(irq_o), .cpu_reset_o(cpu_reset_o));

`default_nettype wire

//--- bench/core_timer_rti_watchdog_tb_top.sv
// self-checking bench for the core timer block
// assumes package, design and checker compiled first
`default_nettype none

module core_timer_rti_watchdog_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int unsigned POR_N = 16;
	typedef struct packed {
		logic wr;
		logic [15:0] a;
		logic [7:0] d;
		logic [7:0] exp;
		logic [7:0] m;
	} row_t;
	logic clk_sys_i, rstn_i, ext_reset_n_i, bus_wr_i, bus_rd_i, irq_o, cpu_reset_o;
	logic [15:0] bus_addr_i;
	logic [7:0] bus_wdata_i, bus_rdata_o, v;
	int mismatches = 0;
	int tests_run = 0;
	int n;
	// writes carry no expectation; reads are masked so live flags do not matter
	row_t rows [8] = '{
		'{1'b1, 16'h0008, 8'h33, 8'h00, 8'h00}, '{1'b0, 16'h0008, 8'h00, 8'h33, 8'h3F},
		'{1'b1, 16'h0008, 8'h0E, 8'h00, 8'h00}, '{1'b0, 16'h0008, 8'h00, 8'h02, 8'h3F},
		'{1'b0, 16'h0000, 8'h00, 8'h00, 8'hFF}, '{1'b0, 16'h000A, 8'h00, 8'h00, 8'hFF},
		'{1'b1, 16'h0008, 8'h01, 8'h00, 8'h00}, '{1'b0, 16'h0008, 8'h00, 8'h01, 8'h3F}};

	core_timer_rti_watchdog #(.POR_CYCLES(POR_N)) dut_u (.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i), .ext_reset_n_i(ext_reset_n_i), .bus_addr_i(bus_addr_i),
		.bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i),
		.bus_rdata_o(bus_rdata_o), .irq_o(irq_o), .cpu_reset_o(cpu_reset_o));

	////////////////////////////////////////
	// tasks
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("FAIL %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// one strobe cycle; read data is held, so it is sampled just after the taking edge
	task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		bus_wr_i <= wr;
		bus_rd_i <= !wr;
		bus_addr_i <= a;
		bus_wdata_i <= d;
		@(posedge clk_sys_i);
		bus_wr_i <= 1'b0;
		bus_rd_i <= 1'b0;
		#1;
	endtask

	// bounded wait on irq (sel 0) or cpu reset (sel 1); n counts edges
	task automatic wait_sig(input logic sel, input logic lvl, input int lim);
		n = 0;
		while ((sel ? cpu_reset_o : irq_o) !== lvl) begin
			@(posedge clk_sys_i);
			#1;
			n++;
			if (n > lim) begin
				chk("wait bound", 0, 1);
				stop_test();
			end
		end
	endtask

	////////////////////////////////////////
	// clock and main sequence
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end

	initial begin
		{rstn_i, bus_wr_i, bus_rd_i, bus_addr_i, bus_wdata_i} = '0;
		ext_reset_n_i = 1'b1;
		repeat (6) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		#1;
		wait_sig(1'b1, 1'b0, 100);
		chk("power-on delay", n, POR_N);
		acc(1'b0, 16'h0008, 8'h00);
		chk("control reset", bus_rdata_o, 8'h03);
		$display("test reset done");
		foreach (rows[i]) begin
			acc(rows[i].wr, rows[i].a, rows[i].d);
			if (!rows[i].wr) chk("row read", bus_rdata_o & rows[i].m, rows[i].exp);
		end
		$display("test rows done");
		acc(1'b0, 16'h0009, 8'h00);
		v = bus_rdata_o;
		acc(1'b1, 16'h0009, 8'hAA);
		acc(1'b0, 16'h0009, 8'h00);
		chk("count step", bus_rdata_o, 8'(v + 8'h01));
		// wrap period, rise to rise; six edges are spent in the clears
		acc(1'b1, 16'h0008, 8'h20);
		wait_sig(1'b0, 1'b1, 1100);
		acc(1'b1, 16'h0008, 8'hA0);
		@(posedge clk_sys_i);
		#1;
		chk("flag kept", irq_o, 1'b1);
		acc(1'b1, 16'h0008, 8'h20);
		@(posedge clk_sys_i);
		#1;
		chk("flag cleared", irq_o, 1'b0);
		wait_sig(1'b0, 1'b1, 1100);
		chk("wrap period", n + 6, 1024);
		acc(1'b1, 16'h0008, 8'h00);
		repeat (1100) @(posedge clk_sys_i);
		acc(1'b0, 16'h0008, 8'h00);
		chk("wrap flag", bus_rdata_o & 8'h80, 8'h80);
		chk("irq masked", irq_o, 1'b0);
		$display("test wrap done");
		// periodic flag at rate zero, serviced watchdog in between
		acc(1'b1, 16'h0008, 8'h10);
		wait_sig(1'b0, 1'b1, 20000);
		acc(1'b0, 16'h0008, 8'h00);
		chk("periodic flag", bus_rdata_o & 8'h40, 8'h40);
		acc(1'b1, 16'h0008, 8'h14);
		@(posedge clk_sys_i);
		#1;
		chk("periodic clear", irq_o, 1'b0);
		acc(1'b1, 16'hFFF0, 8'h00);
		wait_sig(1'b0, 1'b1, 20000);
		chk("periodic period", n + 7, 16384);
		chk("no timeout", cpu_reset_o, 1'b0);
		$display("test periodic done");
		// external reset clears chain and control
		@(posedge clk_sys_i);
		ext_reset_n_i <= 1'b0;
		acc(1'b0, 16'h0008, 8'h00);
		chk("control in reset", bus_rdata_o, 8'h03);
		acc(1'b0, 16'h0009, 8'h00);
		chk("count in reset", bus_rdata_o, 8'h00);
		@(posedge clk_sys_i);
		ext_reset_n_i <= 1'b1;
		wait_sig(1'b1, 1'b0, 4);
		acc(1'b0, 16'h0009, 8'h00);
		chk("count restart", bus_rdata_o < 8'h03, 1'b1);
		$display("test external reset done");
		stop_test();
	end

endmodule // core_timer_rti_watchdog_tb_top

`default_nettype wire
